//--- shared/pwm_timer_pkg.sv
// Constants shared by the PWM timer control and buffer block.
// Assumes byte addresses on a 32-bit register port; all registers are word aligned.
package pwm_timer_pkg;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses).
    // -------------------------------------------------------------------
    localparam logic [31:0] PRESCALE_CONFIG_OFFS = 32'h01d5_0000;
    localparam logic [31:0] DIVIDER_SELECT_OFFS = 32'h01d5_0004;
    localparam logic [31:0] TIMER_RUN_CONTROL_OFFS = 32'h01d5_0008;
    localparam logic [31:0] TIMER0_RELOAD_COUNT_OFFS = 32'h01d5_000c;
    localparam logic [31:0] TIMER0_MATCH_VALUE_OFFS = 32'h01d5_0010;
    localparam logic [31:0] TIMER0_COUNT_VIEW_OFFS = 32'h01d5_0014;
    localparam logic [31:0] TIMER1_RELOAD_COUNT_OFFS = 32'h01d5_0018;
    localparam logic [31:0] TIMER1_MATCH_VALUE_OFFS = 32'h01d5_001c;
    localparam logic [31:0] TIMER1_COUNT_VIEW_OFFS = 32'h01d5_0020;
    localparam logic [31:0] TIMER2_RELOAD_COUNT_OFFS = 32'h01d5_0024;
    localparam logic [31:0] TIMER2_MATCH_VALUE_OFFS = 32'h01d5_0028;
    localparam logic [31:0] TIMER2_COUNT_VIEW_OFFS = 32'h01d5_002c;
    localparam logic [31:0] TIMER3_RELOAD_COUNT_OFFS = 32'h01d5_0030;
    localparam logic [31:0] TIMER3_MATCH_VALUE_OFFS = 32'h01d5_0034;
    localparam logic [31:0] TIMER3_COUNT_VIEW_OFFS = 32'h01d5_0038;
    localparam logic [31:0] TIMER4_RELOAD_COUNT_OFFS = 32'h01d5_003c;
    localparam logic [31:0] TIMER4_MATCH_VALUE_OFFS = 32'h01d5_0040;

    // -------------------------------------------------------------------
    // Counts and widths.
    // -------------------------------------------------------------------
    localparam int NUM_TIMERS = 5;
    localparam int NUM_VIEWS = 4;
    localparam int NUM_DIVIDERS = 5;

    // -------------------------------------------------------------------
    // Control field positions within a timer's four-bit group.
    // -------------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_UPDATE_BIT = 1;
    localparam int CTRL_INVERT_BIT = 2;
    localparam int CTRL_AUTO_BIT = 3;
    localparam int CTRL_TIMER0_BASE = 0;
    localparam int CTRL_TIMER1_BASE = 8;
    localparam int CTRL_DEADZONE_BIT = 4;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_0f1f;

    // -------------------------------------------------------------------
    // Configuration field positions.
    // -------------------------------------------------------------------
    localparam int DEADZONE_LEN_LSB = 24;
    localparam int PRESCALE0_LSB = 0;
    localparam int PRESCALE1_LSB = 8;
    localparam int PRESCALE2_LSB = 16;
    localparam int DIV_SEL_WIDTH = 4;
    localparam logic [31:0] DIVIDER_WRITE_MASK = 32'h000f_ffff;
    localparam logic [3:0] DIV_SEL_MAX = 4'h4;

    // -------------------------------------------------------------------
    // Values after reset.
    // -------------------------------------------------------------------
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [15:0] BUF_RESET = 16'h0000;

endpackage

//--- rtl/tick_divider.sv
// Prescaler plus power-of-two divider serving a pair of timers.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/1ns
module tick_divider (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration.
    input wire logic [7:0] i_prescale,
    input wire logic [3:0] i_sel_a,
    input wire logic [3:0] i_sel_b,
    // Tick pulses.
    output logic o_tick_a,
    output logic o_tick_b
);

    logic [7:0] pre_cnt_reg;
    logic [4:0] div_cnt_reg;
    logic base_pulse;
    logic [4:0] div_pulse;
    logic [2:0] idx_a;
    logic [2:0] idx_b;

    // The prescaler gives one base pulse every prescale plus one clocks.
    assign base_pulse = (pre_cnt_reg == i_prescale);

    // Each divider output fires on every second, fourth ... base pulse.
    genvar k;
    generate
        for (k = 0; k < pwm_timer_pkg::NUM_DIVIDERS; k++) begin : g_div
            assign div_pulse[k] = base_pulse & (&div_cnt_reg[k:0]);
        end
    endgenerate

    // Out-of-range selections fall back to the slowest divider.
    assign idx_a = (i_sel_a > pwm_timer_pkg::DIV_SEL_MAX) ? 3'h4 : i_sel_a[2:0];
    assign idx_b = (i_sel_b > pwm_timer_pkg::DIV_SEL_MAX) ? 3'h4 : i_sel_b[2:0];
    assign o_tick_a = div_pulse[idx_a];
    assign o_tick_b = div_pulse[idx_b];

    // Prescale and divide counters.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt_reg <= 8'h00;
            div_cnt_reg <= 5'h00;
        end else begin
            pre_cnt_reg <= base_pulse ? 8'h00 : pre_cnt_reg + 8'h01;
            div_cnt_reg <= base_pulse ? div_cnt_reg + 5'h01 : div_cnt_reg;
        end
    end

endmodule // tick_divider

//--- rtl/down_channel.sv
// One down-counting PWM channel with compare and reload.
// Assumes tick and control inputs come from logic on the same clock.
`timescale 1ns/1ns
module down_channel (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Control.
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_auto_reload,
    input wire logic i_update,
    // Buffers.
    input wire logic [15:0] i_reload_count,
    input wire logic [15:0] i_match_value,
    // State.
    output logic [15:0] o_count,
    output logic o_level,
    output logic o_expire
);

    logic [15:0] count_reg;
    logic [15:0] cmp_reg;
    logic level_reg;
    logic expire_reg;
    logic step;
    logic at_zero;
    logic do_reload;
    logic do_dec;
    logic do_load;
    logic [15:0] dec_val;

    // Decode what this tick does.
    assign step = i_start & i_tick;
    assign at_zero = (count_reg == 16'h0000);
    assign do_reload = step & at_zero & i_auto_reload;
    assign do_dec = step & ~at_zero;
    assign do_load = i_update | do_reload;
    assign dec_val = count_reg - 16'h0001;

    // Manual update has priority over counting.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= pwm_timer_pkg::BUF_RESET;
            cmp_reg <= pwm_timer_pkg::BUF_RESET;
            level_reg <= 1'b0;
            expire_reg <= 1'b0;
        end else begin
            count_reg <= do_load ? i_reload_count : (do_dec ? dec_val : count_reg);
            cmp_reg <= do_load ? i_match_value : cmp_reg;
            level_reg <= do_load ? 1'b0 : ((do_dec && dec_val == cmp_reg) ? 1'b1 : level_reg);
            expire_reg <= do_dec & (dec_val == 16'h0000);
        end
    end

    assign o_count = count_reg;
    assign o_level = level_reg;
    assign o_expire = expire_reg;

endmodule // down_channel

//--- rtl/pwm_timer_control_buffers.sv
// PWM timer control bits, count and compare buffers, count views and dead zone.
// Assumes a single-cycle register port on i_clk; timers 2 to 4 get their control
// bits from the neighbouring control block through i_upper_ctrl.
`timescale 1ns/1ns
module pwm_timer_control_buffers (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port.
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rd_data,
    // Control bits of timers 2 to 4, four per timer: start, update, invert, auto.
    input wire logic [11:0] i_upper_ctrl,
    // Timer outputs.
    output logic [4:0] o_pwm,
    output logic o_pwm0_n,
    output logic [4:0] o_expire
);

    // -------------------------------------------------------------------
    // Declarations.
    // -------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] prescale_reg;
    logic [31:0] divider_reg;
    logic [15:0] reload_reg [pwm_timer_pkg::NUM_TIMERS];
    logic [15:0] match_reg [pwm_timer_pkg::NUM_TIMERS];
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic [4:0] pwm_reg;
    logic pwm0_n_reg;
    logic [4:0] expire_reg;
    logic [7:0] dz_cnt_reg;
    logic raw0_prev_reg;

    logic wr_ctrl;
    logic wr_prescale;
    logic wr_divider;
    logic [4:0] wr_reload;
    logic [4:0] wr_match;
    logic [4:0] rd_reload;
    logic [4:0] rd_match;
    logic [3:0] rd_view;
    logic [4:0] start_w;
    logic [4:0] update_w;
    logic [4:0] invert_w;
    logic [4:0] auto_w;
    logic [4:0] tick_w;
    logic [15:0] count_w [pwm_timer_pkg::NUM_TIMERS];
    logic [4:0] level_w;
    logic [4:0] expire_w;
    logic [4:0] raw_w;
    logic dz_enable;
    logic [7:0] dz_len;
    logic raw0_edge;
    logic dz_busy;

    // Address tables built from the named offsets.
    logic [31:0] reload_offs [pwm_timer_pkg::NUM_TIMERS];
    logic [31:0] match_offs [pwm_timer_pkg::NUM_TIMERS];
    logic [31:0] view_offs [pwm_timer_pkg::NUM_VIEWS];

    assign reload_offs[0] = pwm_timer_pkg::TIMER0_RELOAD_COUNT_OFFS;
    assign reload_offs[1] = pwm_timer_pkg::TIMER1_RELOAD_COUNT_OFFS;
    assign reload_offs[2] = pwm_timer_pkg::TIMER2_RELOAD_COUNT_OFFS;
    assign reload_offs[3] = pwm_timer_pkg::TIMER3_RELOAD_COUNT_OFFS;
    assign reload_offs[4] = pwm_timer_pkg::TIMER4_RELOAD_COUNT_OFFS;
    assign match_offs[0] = pwm_timer_pkg::TIMER0_MATCH_VALUE_OFFS;
    assign match_offs[1] = pwm_timer_pkg::TIMER1_MATCH_VALUE_OFFS;
    assign match_offs[2] = pwm_timer_pkg::TIMER2_MATCH_VALUE_OFFS;
    assign match_offs[3] = pwm_timer_pkg::TIMER3_MATCH_VALUE_OFFS;
    assign match_offs[4] = pwm_timer_pkg::TIMER4_MATCH_VALUE_OFFS;
    assign view_offs[0] = pwm_timer_pkg::TIMER0_COUNT_VIEW_OFFS;
    assign view_offs[1] = pwm_timer_pkg::TIMER1_COUNT_VIEW_OFFS;
    assign view_offs[2] = pwm_timer_pkg::TIMER2_COUNT_VIEW_OFFS;
    assign view_offs[3] = pwm_timer_pkg::TIMER3_COUNT_VIEW_OFFS;

    // -------------------------------------------------------------------
    // Address decode for the shared configuration registers.
    // -------------------------------------------------------------------

    // Single-register write strobes.
    assign wr_ctrl = i_wr & (i_addr == pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS);
    assign wr_prescale = i_wr & (i_addr == pwm_timer_pkg::PRESCALE_CONFIG_OFFS);
    assign wr_divider = i_wr & (i_addr == pwm_timer_pkg::DIVIDER_SELECT_OFFS);

    // Configuration fields used by the datapath.
    assign dz_enable = ctrl_reg[pwm_timer_pkg::CTRL_DEADZONE_BIT];
    assign dz_len = prescale_reg[pwm_timer_pkg::DEADZONE_LEN_LSB +: 8];

    // -------------------------------------------------------------------
    // Control, configuration and read-back registers.
    // -------------------------------------------------------------------

    // Only the implemented control and divider bits are stored; others read zero.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= pwm_timer_pkg::REG_RESET;
            prescale_reg <= pwm_timer_pkg::REG_RESET;
            divider_reg <= pwm_timer_pkg::REG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_wr_data & pwm_timer_pkg::CTRL_WRITE_MASK;
            end
            if (wr_prescale) begin
                prescale_reg <= i_wr_data;
            end
            if (wr_divider) begin
                divider_reg <= i_wr_data & pwm_timer_pkg::DIVIDER_WRITE_MASK;
            end
        end
    end

    // Read data is registered and stands for one cycle after the strobe.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_data_reg <= pwm_timer_pkg::REG_RESET;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Read mux; unmapped addresses and idle cycles give zero.
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (i_rd) begin
            if (i_addr == pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS) begin
                rd_data_next = ctrl_reg;
            end
            if (i_addr == pwm_timer_pkg::PRESCALE_CONFIG_OFFS) begin
                rd_data_next = prescale_reg;
            end
            if (i_addr == pwm_timer_pkg::DIVIDER_SELECT_OFFS) begin
                rd_data_next = divider_reg;
            end
            for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
                if (rd_reload[i]) begin
                    rd_data_next = {16'h0000, reload_reg[i]};
                end
                if (rd_match[i]) begin
                    rd_data_next = {16'h0000, match_reg[i]};
                end
            end
            for (int i = 0; i < pwm_timer_pkg::NUM_VIEWS; i++) begin
                if (rd_view[i]) begin
                    rd_data_next = {16'h0000, count_w[i]};
                end
            end
        end
    end

    assign o_rd_data = rd_data_reg;

    // -------------------------------------------------------------------
    // Per-timer buffers, control and counters.
    // -------------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < pwm_timer_pkg::NUM_TIMERS; t++) begin : g_timer

            // Buffer decode for this timer.
            assign wr_reload[t] = i_wr & (i_addr == reload_offs[t]);
            assign wr_match[t] = i_wr & (i_addr == match_offs[t]);
            assign rd_reload[t] = (i_addr == reload_offs[t]);
            assign rd_match[t] = (i_addr == match_offs[t]);

            // Count and compare buffers; a write only stores, loading waits.
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    reload_reg[t] <= pwm_timer_pkg::BUF_RESET;
                    match_reg[t] <= pwm_timer_pkg::BUF_RESET;
                end else begin
                    if (wr_reload[t]) begin
                        reload_reg[t] <= i_wr_data[15:0];
                    end
                    if (wr_match[t]) begin
                        match_reg[t] <= i_wr_data[15:0];
                    end
                end
            end

            // Timers 0 and 1 take their bits here, timers 2 to 4 from the port.
            if (t == 0) begin : g_ctl0
                assign start_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER0_BASE
                    + pwm_timer_pkg::CTRL_START_BIT];
                assign update_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER0_BASE
                    + pwm_timer_pkg::CTRL_UPDATE_BIT];
                assign invert_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER0_BASE
                    + pwm_timer_pkg::CTRL_INVERT_BIT];
                assign auto_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER0_BASE
                    + pwm_timer_pkg::CTRL_AUTO_BIT];
            end else if (t == 1) begin : g_ctl1
                assign start_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER1_BASE
                    + pwm_timer_pkg::CTRL_START_BIT];
                assign update_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER1_BASE
                    + pwm_timer_pkg::CTRL_UPDATE_BIT];
                assign invert_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER1_BASE
                    + pwm_timer_pkg::CTRL_INVERT_BIT];
                assign auto_w[t] = ctrl_reg[pwm_timer_pkg::CTRL_TIMER1_BASE
                    + pwm_timer_pkg::CTRL_AUTO_BIT];
            end else begin : g_ctlx
                assign start_w[t] = i_upper_ctrl[4 * (t - 2) + pwm_timer_pkg::CTRL_START_BIT];
                assign update_w[t] = i_upper_ctrl[4 * (t - 2) + pwm_timer_pkg::CTRL_UPDATE_BIT];
                assign invert_w[t] = i_upper_ctrl[4 * (t - 2) + pwm_timer_pkg::CTRL_INVERT_BIT];
                assign auto_w[t] = i_upper_ctrl[4 * (t - 2) + pwm_timer_pkg::CTRL_AUTO_BIT];
            end

            // The down-counter with compare, reload and expiry.
            down_channel u_chan (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_tick(tick_w[t]),
                .i_start(start_w[t]),
                .i_auto_reload(auto_w[t]),
                .i_update(update_w[t]),
                .i_reload_count(reload_reg[t]),
                .i_match_value(match_reg[t]),
                .o_count(count_w[t]),
                .o_level(level_w[t]),
                .o_expire(expire_w[t])
            );

            // Output level after the optional inverter.
            assign raw_w[t] = level_w[t] ^ invert_w[t];
        end
    endgenerate

    // Count views exist for timers 0 to 3 only.
    genvar v;
    generate
        for (v = 0; v < pwm_timer_pkg::NUM_VIEWS; v++) begin : g_view
            assign rd_view[v] = (i_addr == view_offs[v]);
        end
    endgenerate

    // -------------------------------------------------------------------
    // Tick generation: three prescalers shared by timer pairs.
    // -------------------------------------------------------------------

    // Timers 0 and 1.
    tick_divider u_div01 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_prescale(prescale_reg[pwm_timer_pkg::PRESCALE0_LSB +: 8]),
        .i_sel_a(divider_reg[0 * pwm_timer_pkg::DIV_SEL_WIDTH +: 4]),
        .i_sel_b(divider_reg[1 * pwm_timer_pkg::DIV_SEL_WIDTH +: 4]),
        .o_tick_a(tick_w[0]),
        .o_tick_b(tick_w[1])
    );

    // Timers 2 and 3.
    tick_divider u_div23 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_prescale(prescale_reg[pwm_timer_pkg::PRESCALE1_LSB +: 8]),
        .i_sel_a(divider_reg[2 * pwm_timer_pkg::DIV_SEL_WIDTH +: 4]),
        .i_sel_b(divider_reg[3 * pwm_timer_pkg::DIV_SEL_WIDTH +: 4]),
        .o_tick_a(tick_w[2]),
        .o_tick_b(tick_w[3])
    );

    // Timer 4; the second output would serve timer 5, which lives elsewhere.
    tick_divider u_div4 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_prescale(prescale_reg[pwm_timer_pkg::PRESCALE2_LSB +: 8]),
        .i_sel_a(divider_reg[4 * pwm_timer_pkg::DIV_SEL_WIDTH +: 4]),
        .i_sel_b(4'h0),
        .o_tick_a(tick_w[4]),
        .o_tick_b()
    );

    // -------------------------------------------------------------------
    // Dead zone on the timer 0 output pair.
    // -------------------------------------------------------------------

    // A level change of timer 0 starts a dead zone; both outputs stay low during it.
    assign raw0_edge = raw_w[0] ^ raw0_prev_reg;
    assign dz_busy = (dz_cnt_reg != 8'h00);

    // Dead-zone counter runs in timer 0 ticks.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dz_cnt_reg <= 8'h00;
            raw0_prev_reg <= 1'b0;
        end else begin
            raw0_prev_reg <= raw_w[0];
            if (dz_enable && raw0_edge) begin
                dz_cnt_reg <= dz_len;
            end else if (!dz_enable) begin
                dz_cnt_reg <= 8'h00;
            end else if (dz_busy && tick_w[0]) begin
                dz_cnt_reg <= dz_cnt_reg - 8'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // Registered outputs.
    // -------------------------------------------------------------------

    // Timer 0 and its complement are blanked during a dead zone.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwm_reg <= 5'h00;
            pwm0_n_reg <= 1'b0;
            expire_reg <= 5'h00;
        end else begin
            pwm_reg[4:1] <= raw_w[4:1];
            if (dz_enable && (dz_busy || raw0_edge)) begin
                pwm_reg[0] <= 1'b0;
                pwm0_n_reg <= 1'b0;
            end else begin
                pwm_reg[0] <= raw_w[0];
                pwm0_n_reg <= ~raw_w[0];
            end
            expire_reg <= expire_w;
        end
    end

    assign o_pwm = pwm_reg;
    assign o_pwm0_n = pwm0_n_reg;
    assign o_expire = expire_reg;

endmodule // pwm_timer_control_buffers

//--- bench/pwm_timer_props.sv
// Assertions on the register port and outputs of the PWM timer block.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module pwm_timer_props (
    // Watched ports.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rd_data,
    input wire logic [11:0] i_upper_ctrl,
    input wire logic [4:0] o_pwm,
    input wire logic o_pwm0_n,
    input wire logic [4:0] o_expire
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Address classes.
    wire ctl_a = i_addr == pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS;
    wire rl0_a = i_addr == pwm_timer_pkg::TIMER0_RELOAD_COUNT_OFFS;
    wire buf_a = i_addr >= pwm_timer_pkg::TIMER0_RELOAD_COUNT_OFFS && i_addr <= 32'h01d5_0040;
    // A write followed at once by a read of the same place.
    sequence wr_rd(a);
        i_wr && a ##1 i_rd && a && $stable(i_addr);
    endsequence
    a_rd_idle: assert property (!i_rd |=> o_rd_data == 32'h0)
        else $error("read data not zero without a read");
    a_unmapped_rd: assert property (i_rd && i_addr == 32'h01d5_0044 |=> o_rd_data == 32'h0)
        else $error("unmapped read not zero");
    a_buf_upper: assert property (i_rd && buf_a |=> o_rd_data[31:16] == 16'h0)
        else $error("buffer upper half not zero");
    a_ctl_resv: assert property (i_rd && ctl_a |=> (o_rd_data & ~pwm_timer_pkg::CTRL_WRITE_MASK) == 0)
        else $error("unused control bits not zero");
    a_ctl_back: assert property (wr_rd(ctl_a) |=> o_rd_data == ($past(i_wr_data, 2) & 32'h0000_0f1f))
        else $error("control readback wrong");
    a_cnt_back: assert property (wr_rd(rl0_a) |=> o_rd_data == ($past(i_wr_data, 2) & 32'h0000_ffff))
        else $error("count buffer readback wrong");
    a_exp_pulse: assert property (o_expire != 5'h0 |=> (o_expire & $past(o_expire)) == 5'h0)
        else $error("expire pulse longer than one cycle");
    a_pwm_pair: assert property (!(o_pwm[0] && o_pwm0_n))
        else $error("timer 0 output pair both high");
endmodule // pwm_timer_props
bind pwm_timer_control_buffers pwm_timer_props u_props (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_upper_ctrl(i_upper_ctrl), .o_pwm(o_pwm), .o_pwm0_n(o_pwm0_n), .o_expire(o_expire));

//--- bench/tb_top.sv
// Self-checking bench for the PWM timer control and buffer block.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Signals, clock and design
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] i_addr = 32'h0, i_wr_data = 32'h0, o_rd_data, lfsr = 32'heee687f2, d;
    logic i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0, o_pwm0_n;
    logic [11:0] i_upper_ctrl = 12'h0;
    logic [4:0] o_pwm, o_expire;
    logic [31:0] exp_q[$];
    int error_cnt = 0, comparisons = 0, waited = 0;
    // Clock of 100 ns period.
    always #50 i_clk = ~i_clk;
    pwm_timer_control_buffers uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
        .i_upper_ctrl(i_upper_ctrl), .o_pwm(o_pwm), .o_pwm0_n(o_pwm0_n), .o_expire(o_expire));
    // Next pseudo-random word.
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Compares and counts.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Register port cycles; a read notes its expected data.
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge i_clk);
        {i_wr, i_rd, i_addr, i_wr_data} <= {2'b10, a, v};
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] v);
        @(posedge i_clk);
        {i_wr, i_rd, i_addr} <= {2'b01, a};
        exp_q.push_back(v);
    endtask
    task automatic idle();
        @(posedge i_clk);
        {i_wr, i_rd} <= 2'b00;
    endtask
    // Waits, bounded, for one expire pulse of timer n.
    task automatic wait_exp(input int n);
        waited = 0;
        while (o_expire[n] !== 1'b1 && waited < 300) begin
            @(negedge i_clk);
            waited++;
        end
        if (waited == 300) begin
            error_cnt++;
            give_verdict();
        end else begin
            check({31'h0, o_expire[n]}, 32'h1);
            @(negedge i_clk);
        end
    endtask
    // Watches read data in the cycle after each read.
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) if (rd_d) check(o_rd_data, exp_q.pop_front());
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values, then random back-to-back write and read; views ignore writes.
        for (int a = 8; a <= 64; a += 4) rd(32'h01d5_0000 + a, 32'h0);
        for (int a = 12; a <= 68; a += 4) begin
            d = rnd();
            wr(32'h01d5_0000 + a, d);
            rd(32'h01d5_0000 + a, (a % 12 == 8 || a == 68) ? 32'h0 : d & 32'h0000_ffff);
        end
        d = rnd();
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, d);
        rd(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, d & 32'h0000_0f1f);
        // Timers 0 and 1 in interval mode expire twice.
        for (int t = 0; t < 2; t++) begin
            wr(32'h01d5_000c + 12 * t, 32'h5);
            wr(32'h01d5_0010 + 12 * t, 32'h2);
            wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'ha << (8 * t));
            wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'h9 << (8 * t));
            idle();
            wait_exp(t);
            wait_exp(t);
        end
        // Prescale 1 and divide by four give a tick every 8 clocks; reload 3 repeats in 32.
        wr(pwm_timer_pkg::PRESCALE_CONFIG_OFFS, 32'h0200_0001);
        wr(pwm_timer_pkg::DIVIDER_SELECT_OFFS, 32'h0000_0001);
        wr(pwm_timer_pkg::TIMER0_RELOAD_COUNT_OFFS, 32'h3);
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'ha);
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'h9);
        idle();
        wait_exp(0);
        wait_exp(0);
        check(waited + 1, 32'h20);
        // Timer 0 one shot holds at zero with its output set and its complement low.
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'h2);
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'h1);
        idle();
        wait_exp(0);
        repeat (20) @(negedge i_clk);
        check({31'h0, o_pwm[0]}, 32'h1);
        check({31'h0, o_pwm0_n}, 32'h0);
        rd(pwm_timer_pkg::TIMER0_COUNT_VIEW_OFFS, 32'h0);
        // Inverting with the dead zone on blanks the pair for two timer 0 ticks.
        wr(pwm_timer_pkg::TIMER_RUN_CONTROL_OFFS, 32'h15);
        idle();
        repeat (3) @(negedge i_clk);
        check({31'h0, o_pwm[0]}, 32'h0);
        check({31'h0, o_pwm0_n}, 32'h0);
        repeat (40) @(negedge i_clk);
        check({31'h0, o_pwm0_n}, 32'h1);
        check({31'h0, o_pwm[0]}, 32'h0);
        // Timer 2 driven from the upper control nibble.
        wr(pwm_timer_pkg::TIMER2_RELOAD_COUNT_OFFS, 32'h3);
        wr(pwm_timer_pkg::TIMER2_MATCH_VALUE_OFFS, 32'h1);
        idle();
        i_upper_ctrl <= 12'h00a;
        @(posedge i_clk);
        i_upper_ctrl <= 12'h009;
        wait_exp(2);
        wait_exp(2);
        give_verdict();
    end
endmodule // tb_top
